// File: pkg/acmp_defs.svh
// Register map, field positions and reset values of the comparator control block.
// Assumes inclusion by the design file and the bench only.
`ifndef ACMP_DEFS_SVH
`define ACMP_DEFS_SVH
`define MIS_OFFSET 12'h000
`define RIS_OFFSET 12'h004
`define INTEN_OFFSET 12'h008
`define REFCTL_OFFSET 12'h010
`define STAT0_OFFSET 12'h020
`define CTL0_OFFSET 12'h024
`define CMP_STRIDE 12'h020
`define REF_EN_BIT 9
`define REF_RNG_BIT 8
`define CTL_SRC_LSB 9
`define CTL_INV_BIT 1
`define CTL_ISEN_LSB 2
`define CTL_ALT_BIT 11
`define STAT_OVAL_BIT 1
`define LADDER_LOW_UNITS 5'h1F
`define LADDER_HIGH_UNITS 5'h17
`define LADDER_LOW_OFFSET 5'h08
`define REG_RESET 32'h0000_0000
`endif

// File: pkg/acmp_pkg.sv
// Types shared by the comparator control block.
// Assumes acmp_defs.svh is on the include path.
`default_nettype none
package acmp_pkg;
    typedef enum logic [1:0]
    {
        SRC_OWN_PIN = 2'b00,
        SRC_ALT_PIN = 2'b01,
        SRC_REFERENCE = 2'b10,
        SRC_RESERVED = 2'b11
    } source_sel_t;
    typedef enum logic [1:0]
    {
        EV_LEVEL_LOW = 2'b00,
        EV_FALLING = 2'b01,
        EV_RISING = 2'b10,
        EV_BOTH = 2'b11
    } event_sense_t;
    typedef struct packed
    {
        logic alt_function;
        source_sel_t positive_source_select;
        event_sense_t sense;
        logic invert;
    } cmp_ctl_t;
    typedef struct packed
    {
        logic enable;
        logic reference_range_select;
        logic [3:0] tap_code;
    } ref_ctl_t;
    typedef struct packed
    {
        logic [4:0] numerator;
        logic [4:0] ladder_units;
    } ladder_tap_t;
endpackage : acmp_pkg
`default_nettype wire

// File: verilog/analog_comparator_control.sv
// AHB-Lite slave controlling three analog comparators, their reference ladder,
// result polarity, interrupts and alternate-function output pins.
// Assumes raw comparator results arrive asynchronously; the analog mux and ladder
// follow the select and tap outputs.
`include "acmp_defs.svh"
`default_nettype none
module analog_comparator_control
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Analog side
    input wire logic [2:0] compare_result,
    output logic [5:0] positive_source_select,
    output logic [2:0] own_pin_as_input,
    output acmp_pkg::ladder_tap_t reference_tap,
    output logic reference_enable,
    // Pins and interrupt
    output logic [2:0] cmp_output_pin,
    output logic [2:0] cmp_output_pin_oe,
    output logic irq
);
    import acmp_pkg::*;

    // ==========================================
    // Register state
    cmp_ctl_t ctl [3];
    ref_ctl_t refctl;
    logic [2:0] raw_status;
    logic [2:0] int_enable;
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] prev_val;
    logic wr_pend;
    logic [11:0] wr_addr;

    // ==========================================
    // Bus decode
    wire logic take = hsel & hready & htrans[1];
    wire logic is_wr = wr_pend;
    wire logic [2:0] mis_clear = (is_wr && wr_addr == `MIS_OFFSET) ? hwdata[2:0] : 3'h0;

    function automatic logic is_ctl(input logic [11:0] a, input int n);
        return a == 12'(`CTL0_OFFSET + n * `CMP_STRIDE);
    endfunction : is_ctl

    function automatic logic is_stat(input logic [11:0] a, input int n);
        return a == 12'(`STAT0_OFFSET + n * `CMP_STRIDE);
    endfunction : is_stat

    // ==========================================
    // Synchroniser fill after reset
    // events held off until the chain holds real results
    // Reset zeros in the chain would otherwise pass for a level-low event
    logic [2:0] sync_fill;
    wire logic sync_ready = sync_fill[2];
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            sync_fill <= 3'h0;
        else
            sync_fill <= {sync_fill[1:0], 1'b1};
    end

    // ==========================================
    // Per-comparator logic
    logic [2:0] oval;
    logic [2:0] evt;
    logic [31:0] ctl_word [3];
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : cmp
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    sync_a[g] <= 1'b0;
                    sync_b[g] <= 1'b0;
                end
                else
                begin
                    sync_a[g] <= compare_result[g];
                    sync_b[g] <= sync_a[g];
                end
            end
            assign oval[g] = sync_b[g] ^ ctl[g].invert;
            assign evt[g] = !sync_ready ? 1'b0 :
                            (ctl[g].sense == EV_LEVEL_LOW) ? ~oval[g] :
                            (ctl[g].sense == EV_FALLING) ? (prev_val[g] & ~oval[g]) :
                            (ctl[g].sense == EV_RISING) ? (~prev_val[g] & oval[g]) :
                            (prev_val[g] ^ oval[g]);
            assign ctl_word[g] = {20'h0, ctl[g].alt_function, ctl[g].positive_source_select,
                                  5'h0, ctl[g].sense, ctl[g].invert, 1'b0};
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    ctl[g] <= '0;
                    prev_val[g] <= 1'b0;
                end
                else
                begin
                    prev_val[g] <= oval[g];
                    if (is_wr && is_ctl(wr_addr, g))
                    begin
                        ctl[g].alt_function <= hwdata[`CTL_ALT_BIT];
                        ctl[g].positive_source_select <= source_sel_t'(hwdata[`CTL_SRC_LSB +: 2]);
                        ctl[g].sense <= event_sense_t'(hwdata[`CTL_ISEN_LSB +: 2]);
                        ctl[g].invert <= hwdata[`CTL_INV_BIT];
                    end
                end
            end
            // raw sticky; set beats write-one clear
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    raw_status[g] <= 1'b0;
                else if (evt[g])
                    raw_status[g] <= 1'b1;
                else if (mis_clear[g])
                    raw_status[g] <= 1'b0;
            end
        end
    endgenerate

    // ==========================================
    // Reference ladder
    // disabled reference taps ground
    wire logic [4:0] code_ext = {1'b0, refctl.tap_code};
    wire ladder_tap_t next_tap = !refctl.enable ? ladder_tap_t'(10'h000) :
        refctl.reference_range_select ? ladder_tap_t'({code_ext, `LADDER_HIGH_UNITS}) :
        ladder_tap_t'({5'(code_ext + `LADDER_LOW_OFFSET), `LADDER_LOW_UNITS});

    // ==========================================
    // Read mux
    wire logic [2:0] masked = raw_status & int_enable;
    wire logic [31:0] next_rdata =
        (wr_addr == `MIS_OFFSET) ? {29'h0, masked} :
        (wr_addr == `RIS_OFFSET) ? {29'h0, raw_status} :
        (wr_addr == `INTEN_OFFSET) ? {29'h0, int_enable} :
        (wr_addr == `REFCTL_OFFSET) ? {22'h0, refctl.enable, refctl.reference_range_select, 4'h0,
                                       refctl.tap_code} :
        is_ctl(wr_addr, 0) ? ctl_word[0] :
        is_ctl(wr_addr, 1) ? ctl_word[1] :
        is_ctl(wr_addr, 2) ? ctl_word[2] :
        is_stat(wr_addr, 0) ? {30'h0, oval[0], 1'b0} :
        is_stat(wr_addr, 1) ? {30'h0, oval[1], 1'b0} :
        is_stat(wr_addr, 2) ? {30'h0, oval[2], 1'b0} : 32'h0;
    logic rd_pend;

    // ==========================================
    // Bus and shared registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            wr_addr <= 12'h000;
            hrdata <= `REG_RESET;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            int_enable <= 3'h0;
            refctl <= '0;
            reference_tap <= '0;
            reference_enable <= 1'b0;
            positive_source_select <= 6'h00;
            own_pin_as_input <= 3'h0;
            cmp_output_pin <= 3'h0;
            cmp_output_pin_oe <= 3'h0;
            irq <= 1'b0;
        end
        else
        begin
            // One wait state per access: address latched, data phase finished next edge
            hreadyout <= !(take && !(wr_pend || rd_pend));
            wr_pend <= take && hwrite && !(wr_pend || rd_pend);
            rd_pend <= take && !hwrite && !(wr_pend || rd_pend);
            if (take && !(wr_pend || rd_pend))
                wr_addr <= {haddr[11:2], 2'b00};
            if (rd_pend)
                hrdata <= next_rdata;
            if (is_wr && wr_addr == `INTEN_OFFSET)
                int_enable <= hwdata[2:0];
            if (is_wr && wr_addr == `REFCTL_OFFSET)
                refctl <= '{enable: hwdata[`REF_EN_BIT], reference_range_select: hwdata[`REF_RNG_BIT],
                            tap_code: hwdata[3:0]};
            reference_tap <= next_tap;
            reference_enable <= refctl.enable;
            positive_source_select <= {ctl[2].positive_source_select, ctl[1].positive_source_select,
                                       ctl[0].positive_source_select};
            own_pin_as_input[0] <= (ctl[0].positive_source_select == SRC_OWN_PIN)
                || (ctl[0].positive_source_select == SRC_ALT_PIN);
            own_pin_as_input[1] <= ctl[1].positive_source_select == SRC_OWN_PIN;
            own_pin_as_input[2] <= ctl[2].positive_source_select == SRC_OWN_PIN;
            // pin carries result only with alternate select
            for (int i = 0; i < 3; i++)
            begin
                cmp_output_pin[i] <= ctl[i].alt_function & oval[i];
                cmp_output_pin_oe[i] <= ctl[i].alt_function;
            end
            irq <= |masked;
        end
    end

    // ==========================================
    // Checks
    ref_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !refctl.enable |=> reference_tap == '0)
        else $error("reference tap not grounded while disabled");
    ladder_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
        refctl.enable && !refctl.reference_range_select |=> reference_tap.ladder_units == 5'h1F
            && reference_tap.numerator == 5'($past(refctl.tap_code) + 5'h08))
        else $error("low ladder tap wrong");
    ladder_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
        refctl.enable && refctl.reference_range_select |=> reference_tap.ladder_units == 5'h17
            && reference_tap.numerator == {1'b0, $past(refctl.tap_code)})
        else $error("high ladder tap wrong");
    pin_gpio_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !ctl[1].alt_function |=> !cmp_output_pin_oe[1] && !cmp_output_pin[1])
        else $error("pin driven without alternate select");
    raw_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
        evt[0] |=> raw_status[0])
        else $error("raw status missed event");
    clear_w1c_a: assert property (@(posedge hclk) disable iff (!hresetn)
        mis_clear[2] && !evt[2] |=> !raw_status[2])
        else $error("write one did not clear");
    sync_delay_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(sync_b[0]) |-> $past(compare_result[0], 2))
        else $error("synchroniser depth wrong");
    polarity_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !ctl[0].invert && sync_b[0] && ctl[0].alt_function |=> cmp_output_pin[0])
        else $error("result polarity wrong");
    src_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ctl[0].positive_source_select == SRC_ALT_PIN |=> own_pin_as_input[0])
        else $error("comparator 0 code 01 not own pin");
    irq_mask_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (raw_status & int_enable) == 3'h0 |=> !irq)
        else $error("interrupt without enabled status");
    irq_raise_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (raw_status & int_enable) != 3'h0 |=> irq)
        else $error("interrupt missing for enabled status");
    raw_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        raw_status[1] && !mis_clear[1] |=> raw_status[1])
        else $error("raw status lost without clear");
    clear_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        is_wr && wr_addr == `MIS_OFFSET && !hwdata[0] && raw_status[0] |=> raw_status[0])
        else $error("write zero cleared status");
    independent_a: assert property (@(posedge hclk) disable iff (!hresetn)
        evt == 3'b010 && mis_clear == 3'h0 |=> raw_status[0] == $past(raw_status[0])
            && raw_status[2] == $past(raw_status[2]))
        else $error("event leaked to another comparator");
    fill_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !sync_ready |=> raw_status == 3'h0)
        else $error("status set before synchroniser filled");
    sync_two_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(sync_b[1]) |-> !$past(compare_result[1], 2))
        else $error("synchroniser depth wrong on fall");

    // ==========================================
    // Checks: source select, pins and status read
    src_ref_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ctl[0].positive_source_select == SRC_REFERENCE |=> !own_pin_as_input[0] && positive_source_select[1:0] == 2'h2)
        else $error("comparator 0 reference source wrong");
    src_one_alt_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ctl[1].positive_source_select == SRC_ALT_PIN |=> !own_pin_as_input[1] && positive_source_select[3:2] == 2'h1)
        else $error("comparator 1 shared pin source wrong");
    src_two_own_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ctl[2].positive_source_select == SRC_OWN_PIN |=> own_pin_as_input[2] && positive_source_select[5:4] == 2'h0)
        else $error("comparator 2 own pin source wrong");
    pin_alt_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ctl[2].alt_function |=> cmp_output_pin_oe[2] && cmp_output_pin[2] == $past(oval[2]))
        else $error("alternate pin not carrying result");
    pin_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !ctl[0].alt_function |=> !cmp_output_pin_oe[0])
        else $error("comparator 0 pin enabled without alternate select");
    stat_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_pend && is_stat(wr_addr, 2) |=> hrdata[`STAT_OVAL_BIT] == $past(oval[2]))
        else $error("status read does not show result");

    // ==========================================
    // Checks: reference ladder outputs
    ref_en_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !reference_enable |-> reference_tap == 10'h000)
        else $error("tap not grounded with reference off");
    tap_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
        reference_tap.ladder_units == 5'h17 |-> reference_tap.numerator <= 5'h0F)
        else $error("high ladder tap out of range");
    tap_low_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
        reference_tap.ladder_units == 5'h1F |-> reference_tap.numerator >= 5'h08 && reference_tap.numerator <= 5'h17)
        else $error("low ladder tap out of range");

    // ==========================================
    // Checks: register access
    ready_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
        take && !wr_pend && !rd_pend |=> !hreadyout ##1 hreadyout)
        else $error("access wait state wrong");
    ready_back_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !hreadyout |=> hreadyout)
        else $error("ready held low too long");
    read_data_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_pend && wr_addr == `RIS_OFFSET |=> hrdata == {29'h0, $past(raw_status)})
        else $error("raw status read wrong");
    inten_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        is_wr && wr_addr == `INTEN_OFFSET |=> int_enable == $past(hwdata[2:0]))
        else $error("enable write lost");
    ctl_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        is_wr && is_ctl(wr_addr, 1) |=> ctl[1].positive_source_select == $past(hwdata[`CTL_SRC_LSB +: 2]))
        else $error("control write lost");
endmodule : analog_comparator_control
`default_nettype wire

// File: test/acmp_far_side.sv
// Far-side model: analog input pins and the internal reference ladder.
// Assumes the bench sets pin voltages in millivolts; supply is fixed.
`default_nettype none
module acmp_far_side
    import acmp_pkg::*;
#(
    parameter int AVDD_MV = 3300
)
(
    // Mux and ladder controls
    input wire logic [5:0] positive_source_select,
    input wire acmp_pkg::ladder_tap_t reference_tap,
    input wire logic reference_enable,
    // Pin voltages
    input var int v_own [3],
    input var int v_neg [3],
    // Comparator outputs, asynchronous
    output logic [2:0] compare_result
);
    int vref;
    int vpos [3];
    // ========================================
    // Reference ladder
    // ground unless enabled
    always_comb
    begin
        vref = 0;
        if (reference_enable && reference_tap.ladder_units != 5'h00)
            vref = AVDD_MV * reference_tap.numerator / reference_tap.ladder_units;
    end
    // ========================================
    // Positive mux and compare
    // mux and compare
    always_comb
    begin
        for (int k = 0; k < 3; k++)
        begin
            case (positive_source_select[2 * k +: 2])
                2'b00: vpos[k] = v_own[k];
                2'b01: vpos[k] = v_own[0];
                2'b10: vpos[k] = vref;
                // Reserved code: no defined input, result forced low
                default: vpos[k] = v_neg[k];
            endcase
            compare_result[k] = v_neg[k] < vpos[k];
        end
    end
endmodule : acmp_far_side
`default_nettype wire

// File: test/analog_comparator_control_bench.sv
// Self-checking bench for the comparator control block.
// Assumes the far-side model stands in for pins and the reference ladder.
`include "acmp_defs.svh"
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module analog_comparator_control_bench
    import acmp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, reference_enable, irq;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize, compare_result, own_pin_as_input, cmp_output_pin, cmp_output_pin_oe;
    logic [31:0] hwdata, hrdata, q;
    logic [5:0] positive_source_select;
    ladder_tap_t reference_tap;
    int v_own [3];
    int v_neg [3];
    int num_errors, checked;
    logic [11:0] ref_val [5] = '{12'h100, 12'h005, 12'h204, 12'h20F, 12'h30F};
    logic [9:0] ref_exp [5] = '{10'h000, 10'h000, {5'h0C, 5'h1F}, {5'h17, 5'h1F}, {5'h0F, 5'h17}};
    assign hready = hreadyout;
    analog_comparator_control analog_comparator_control_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .compare_result(compare_result),
        .positive_source_select(positive_source_select), .own_pin_as_input(own_pin_as_input),
        .reference_tap(reference_tap), .reference_enable(reference_enable), .cmp_output_pin(cmp_output_pin),
        .cmp_output_pin_oe(cmp_output_pin_oe), .irq(irq));
    acmp_far_side acmp_far_side_i (.positive_source_select(positive_source_select),
        .reference_tap(reference_tap), .reference_enable(reference_enable), .v_own(v_own), .v_neg(v_neg),
        .compare_result(compare_result));
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // ========================================
    // Bus tasks
    task automatic final_report();
        $display("Counts: checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report
    // Settled value checked at negedge, taken at the next rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(negedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
        begin
            num_errors++;
            final_report();
        end
        q = hrdata;
        @(posedge hclk);
    endtask : wait_ready
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
    endtask : bus
    task automatic expect_rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        `CHK("read data", e, q)
        `CHK("response", 1'b0, hresp)
    endtask : expect_rd
    // ========================================
    // Main sequence
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        num_errors = 0;
        checked = 0;
        v_neg = '{1000, 1000, 1000};
        v_own = '{2000, 2000, 2000};
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        `CHK("pin enable", 3'h0, cmp_output_pin_oe)
        for (int i = 0; i < 3; i++) expect_rd(12'(`CTL0_OFFSET + `CMP_STRIDE * i), `REG_RESET);
        expect_rd(`MIS_OFFSET, `REG_RESET);
        expect_rd(`RIS_OFFSET, `REG_RESET);
        expect_rd(`INTEN_OFFSET, `REG_RESET);
        expect_rd(12'h0FC, `REG_RESET);
        $display("Test done: reset values");
        for (int i = 0; i < 5; i++)
        begin
            // first two entries are quiet ground settings
            bus(1'b1, `REFCTL_OFFSET, {20'h0, ref_val[i]});
            expect_rd(`REFCTL_OFFSET, {20'h0, ref_val[i]});
            `CHK("ladder tap", ref_exp[i], reference_tap)
            `CHK("ref enable", ref_val[i][9], reference_enable)
        end
        $display("Test done: reference ladder");
        // sources programmed before results are used
        for (int c = 0; c < 3; c++)
            for (int k = 0; k < 3; k++)
            begin
                bus(1'b1, 12'(`CTL0_OFFSET + `CMP_STRIDE * k), 32'((c << `CTL_SRC_LSB) | (2 << `CTL_ISEN_LSB)));
                if (c == 0 && k == 0) v_own <= '{2000, 500, 500};
                repeat (4) @(posedge hclk);
                `CHK("source", 2'(c), positive_source_select[2 * k +: 2])
                `CHK("own pin", c == 0 || (k == 0 && c == 1), own_pin_as_input[k])
                expect_rd(12'(`STAT0_OFFSET + `CMP_STRIDE * k), 32'((c != 0 || k == 0) << `STAT_OVAL_BIT));
            end
        $display("Test done: source select");
        bus(1'b1, `MIS_OFFSET, 32'h0000_0007);
        expect_rd(`RIS_OFFSET, 32'h0000_0000);
        bus(1'b1, `INTEN_OFFSET, 32'h0000_0005);
        bus(1'b1, `REFCTL_OFFSET, 32'h0000_0100);
        repeat (6) @(posedge hclk);
        bus(1'b1, `REFCTL_OFFSET, 32'h0000_030F);
        repeat (6) @(posedge hclk);
        expect_rd(`RIS_OFFSET, 32'h0000_0007);
        expect_rd(`MIS_OFFSET, 32'h0000_0005);
        `CHK("irq", 1'b1, irq)
        bus(1'b1, `MIS_OFFSET, 32'h0000_0000);
        expect_rd(`MIS_OFFSET, 32'h0000_0005);
        bus(1'b1, `MIS_OFFSET, 32'h0000_0001);
        expect_rd(`MIS_OFFSET, 32'h0000_0004);
        bus(1'b1, `MIS_OFFSET, 32'h0000_0004);
        expect_rd(`RIS_OFFSET, 32'h0000_0002);
        `CHK("irq", 1'b0, irq)
        bus(1'b1, `INTEN_OFFSET, 32'h0000_0007);
        expect_rd(`MIS_OFFSET, 32'h0000_0002);
        `CHK("irq", 1'b1, irq)
        bus(1'b1, `MIS_OFFSET, 32'h0000_0002);
        repeat (2) @(posedge hclk);
        `CHK("irq", 1'b0, irq)
        $display("Test done: interrupts");
        // Falling sense on comparator 0, both edges on 1, rising stays on 2
        bus(1'b1, `CTL0_OFFSET, 32'h0000_0404);
        bus(1'b1, 12'(`CTL0_OFFSET + `CMP_STRIDE), 32'h0000_040C);
        bus(1'b1, `REFCTL_OFFSET, 32'h0000_0100);
        repeat (6) @(posedge hclk);
        expect_rd(`RIS_OFFSET, 32'h0000_0003);
        bus(1'b1, `MIS_OFFSET, 32'h0000_0007);
        bus(1'b1, `REFCTL_OFFSET, 32'h0000_030F);
        repeat (6) @(posedge hclk);
        expect_rd(`RIS_OFFSET, 32'h0000_0006);
        $display("Test done: event sense");
        // pins used as outputs with alternate select, sources set to the reference
        for (int v = 1; v >= 0; v--)
        begin
            for (int k = 0; k < 3; k++)
                bus(1'b1, 12'(`CTL0_OFFSET + `CMP_STRIDE * k), 32'(2 << `CTL_SRC_LSB | 1 << `CTL_ALT_BIT | v << 1));
            repeat (4) @(posedge hclk);
            `CHK("pin enable", 3'h7, cmp_output_pin_oe)
            `CHK("pin value", v != 0 ? 3'h0 : 3'h7, cmp_output_pin)
        end
        $display("Test done: output pins");
        final_report();
    end
endmodule : analog_comparator_control_bench
`default_nettype wire
